// File: rtl/qdl_params.svh
/*
  Constants of the quad DAC serial loader: frame layout, register
  offsets, field positions and reset values.
  Assumes inclusion by bare name from the package and the main module.
*/
`ifndef QDL_PARAMS_SVH
`define QDL_PARAMS_SVH

// ----------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------
`define QDL_FRAME_BITS     16
`define QDL_CNT_W          5
`define QDL_CODE_W         12
`define QDL_CHAN_HI        15
`define QDL_CHAN_LO        14
`define QDL_GAIN_BIT       13
`define QDL_BUF_BIT        12
`define QDL_CODE_HI        11

// ----------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------
`define QDL_ADDR_W         8
`define QDL_OFF_CTRL       8'h00
`define QDL_OFF_STAT       8'h04
`define QDL_OFF_CH0        8'h10
`define QDL_OFF_CH3        8'h1c

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define QDL_CTRL_RES_LSB   0
`define QDL_CTRL_RST       2'h0
`define QDL_CH_DAC_LSB     16
`define QDL_CH_PEND_BIT    31
`define QDL_STAT_ARMED_BIT 8
`define QDL_STAT_CHAIN_BIT 9
`define QDL_STAT_FRAMES_LSB 16
`define QDL_ENTRY_RST      14'h0000

`endif

// File: rtl/qdl_pkg.sv
/*
  Types of the quad DAC serial loader.
  Assumes the constants header sits beside it in rtl/.
*/
`include "qdl_params.svh"

package qdl_pkg;

  // One channel entry: gain, reference buffering, code
  typedef struct packed {
    logic                    gain;
    logic                    buf_ref;
    logic [`QDL_CODE_W-1:0]  code;
  } qdl_entry_t;

  typedef logic [`QDL_CODE_W-1:0] qdl_code_t;

  // Frame sequencer, one-hot
  typedef enum logic [2:0] {
    QDL_ST_IDLE  = 3'b001,
    QDL_ST_SHIFT = 3'b010,
    QDL_ST_HOLD  = 3'b100
  } qdl_state_t;

  // Converter resolution variant
  typedef enum logic [1:0] {
    QDL_RES_12 = 2'h0,
    QDL_RES_10 = 2'h1,
    QDL_RES_8  = 2'h2
  } qdl_res_t;

endpackage : qdl_pkg

// File: rtl/qdl_sync.sv
/*
  Two-stage synchroniser for a group of slow level inputs.
  Assumes each input is a level held for several pclk periods.
*/
`timescale 1ns/10ps

module qdl_sync
  import qdl_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Reset to zero; rst_val inverts chosen bits on the way in, so the
  // user inverts them back and reset still takes only constants
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in ^ rst_val;
      sync_out <= meta_q;
    end
  end

endmodule : qdl_sync

// File: rtl/qdl_loader.sv
/*
  Digital core of a quad voltage-output DAC: 3-wire serial loader,
  input and DAC registers per channel, daisy-chain output and an APB
  slave for resolution setting and readback.
  Assumes sclk, sync_n, din and the strobes come from pins outside the
  pclk domain and are slow against pclk (several samples per level).
*/
// Design decisions made here: the register addresses and register access over APB.
// What this block does
// - Frames fill a 16-bit shift register MSB first on the serial clock.
// - Word bits 15:14 pick channel A, B, C or D.
// - Bit 13 sets the channel gain: one or two times reference.
// - Bit 12 sets the channel reference buffered or unbuffered.
// - Resolution variant keeps 12, 10 or 8 code bits.
// - Codes are straight binary and pass unchanged to the outputs.
// - Frame strobe high blocks all serial data.
// - After strobe falls, one bit shifts per falling clock, 16 pulses.
// - Stand-alone mode ignores clocks after the 16th until re-framed.
// - A complete frame loads the addressed input register.
// - Strobe rising before the 16th edge aborts with no update.
// - Load strobe high holds every DAC register.
// - Load strobe low updates DAC registers after each complete write.
// - A DAC register reloads only when its input register changed.
// - Clear input zeroes input and DAC registers at once.
// - Chain mode keeps shifting; bits past 16 leave on serial out.
// - Serial out changes on rising clock, valid at next falling edge.
// - Power-up: normal, unbuffered, gain one, all registers zero.
`timescale 1ns/10ps

`include "qdl_params.svh"

module qdl_loader
  import qdl_pkg::*;
(
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`QDL_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Serial link pins
  input  wire logic                    sclk,
  input  wire logic                    sync_n,
  input  wire logic                    din,
  output logic                         serial_out,
  // Control pins
  input  wire logic                    chain_enable,
  input  wire logic                    load_outputs_n,
  input  wire logic                    async_clear_n,
  // Converter side
  output qdl_code_t [3:0]              dac_code,
  output logic      [3:0]              dac_gain,
  output logic      [3:0]              dac_buf_ref
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  logic       sclk_s;
  logic       sync_n_s;
  logic       din_s;
  logic       chain_s;
  logic       load_n_s;

  // Active-low and idle-high pins are inverted in the chain so that
  // they read as high from reset onward
  qdl_sync #(.WIDTH(5)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({sclk, sync_n, din, chain_enable, load_outputs_n}),
    .rst_val  (5'h19),
    .sync_out (pins_s)
  );

  assign sclk_s   = pins_s[4] ^ 1'b1;
  assign sync_n_s = pins_s[3] ^ 1'b1;
  assign din_s    = pins_s[2];
  assign chain_s  = pins_s[1];
  assign load_n_s = pins_s[0] ^ 1'b1;

  // Clear acts without the clock on the code registers only
  logic clr_rst_n;
  assign clr_rst_n = presetn & async_clear_n;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic sclk_prev_q;
  logic sync_prev_q;
  logic sclk_fall;
  logic sclk_rise;
  logic sync_fall;
  logic sync_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_prev_q <= 1'b1;
      sync_prev_q <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      sync_prev_q <= sync_n_s;
    end
  end

  assign sclk_fall = sclk_prev_q & ~sclk_s;
  assign sclk_rise = ~sclk_prev_q & sclk_s;
  assign sync_fall = sync_prev_q & ~sync_n_s;
  assign sync_rise = ~sync_prev_q & sync_n_s;

  // ----------------------------------------------------------------
  // Frame sequencer and shift register
  // ----------------------------------------------------------------
  qdl_state_t                     state_q;
  qdl_state_t                     state_d;
  logic [`QDL_FRAME_BITS-1:0]     shift_q;
  logic [`QDL_CNT_W-1:0]          count_q;
  logic                           full_cnt;
  logic                           take_bit;
  logic                           commit;

  assign full_cnt = (count_q == `QDL_CNT_W'(`QDL_FRAME_BITS));

  // A bit is taken only inside a frame; in chain mode the count no
  // longer gates the clock
  assign take_bit = (state_q == QDL_ST_SHIFT) & sclk_fall
                  & ~sync_n_s & (chain_s | ~full_cnt);

  // Stand-alone commits on the 16th edge; chain waits for the strobe
  always_comb
  begin
    commit = 1'b0;
    if (state_q == QDL_ST_SHIFT)
    begin
      if (!chain_s && take_bit
          && count_q == `QDL_CNT_W'(`QDL_FRAME_BITS - 1))
        commit = 1'b1;
      else if (chain_s && sync_rise && full_cnt)
        commit = 1'b1;
    end
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      QDL_ST_IDLE:
        if (sync_fall)
          state_d = QDL_ST_SHIFT;
      QDL_ST_SHIFT:
        if (sync_rise)
          state_d = QDL_ST_IDLE;
        else if (!chain_s && commit)
          state_d = QDL_ST_HOLD;
      QDL_ST_HOLD:
        if (sync_rise)
          state_d = QDL_ST_IDLE;
      default:
        state_d = QDL_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= QDL_ST_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_q <= '0;
      count_q <= '0;
    end
    else if (sync_fall)
      count_q <= '0;
    else if (take_bit)
    begin
      shift_q <= {shift_q[`QDL_FRAME_BITS-2:0], din_s};
      if (!full_cnt)
        count_q <= count_q + `QDL_CNT_W'(1);
    end
  end

  // Next bit out is the MSB, which leaves at the coming falling edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      serial_out <= 1'b0;
    else if (sclk_rise)
      serial_out <= shift_q[`QDL_FRAME_BITS-1];
  end

  // ----------------------------------------------------------------
  // Resolution
  // ----------------------------------------------------------------
  qdl_res_t res_q;

  // Dropped low bits read as zero so the code keeps its 12-bit weight
  function automatic qdl_code_t mask_code(qdl_code_t c, qdl_res_t r);
    qdl_code_t m;
    m = '1;
    unique case (r)
      QDL_RES_10: m = 12'hffc;
      QDL_RES_8:  m = 12'hff0;
      default:    m = 12'hfff;
    endcase
    return c & m;
  endfunction : mask_code

  // ----------------------------------------------------------------
  // Input and DAC registers
  // ----------------------------------------------------------------
  qdl_entry_t [3:0] in_q;
  qdl_entry_t [3:0] dac_q;
  logic       [3:0] pend_q;
  qdl_entry_t       new_entry;
  logic       [1:0] chan;
  logic       [3:0] upd;

  assign chan = shift_q[`QDL_CHAN_HI:`QDL_CHAN_LO];

  always_comb
  begin
    new_entry.gain    = shift_q[`QDL_GAIN_BIT];
    new_entry.buf_ref = shift_q[`QDL_BUF_BIT];
    new_entry.code    = mask_code(shift_q[`QDL_CODE_HI:0], res_q);
  end

  // Commit looks at the shift register after the last bit landed:
  // in stand-alone mode that bit lands in the same cycle, so fold it in
  qdl_entry_t       load_entry;
  logic       [1:0] load_chan;

  always_comb
  begin
    load_entry = new_entry;
    load_chan  = chan;
    if (!chain_s)
    begin
      load_entry.gain    = shift_q[`QDL_GAIN_BIT-1];
      load_entry.buf_ref = shift_q[`QDL_BUF_BIT-1];
      load_entry.code    = mask_code({shift_q[`QDL_CODE_HI-1:0], din_s},
                                     res_q);
      load_chan          = shift_q[`QDL_CHAN_HI-1:`QDL_CHAN_LO-1];
    end
  end

  // Load strobe low passes only channels whose input moved
  assign upd = pend_q & {4{~load_n_s}};

  always_ff @(posedge pclk or negedge clr_rst_n)
  begin
    if (!clr_rst_n)
    begin
      in_q   <= {4{`QDL_ENTRY_RST}};
      pend_q <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        // A commit in the update cycle keeps the flag set
        if (commit && load_chan == 2'(i))
        begin
          in_q[i]   <= load_entry;
          pend_q[i] <= 1'b1;
        end
        else if (upd[i])
          pend_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge clr_rst_n)
  begin
    if (!clr_rst_n)
      dac_q <= {4{`QDL_ENTRY_RST}};
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (upd[i])
          dac_q[i] <= in_q[i];
      end
    end
  end

  // Codes leave as straight binary, no remapping
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      dac_code[i]    = dac_q[i].code;
      dac_gain[i]    = dac_q[i].gain;
      dac_buf_ref[i] = dac_q[i].buf_ref;
    end
  end

  // ----------------------------------------------------------------
  // Frame counter for status
  // ----------------------------------------------------------------
  logic [15:0] frames_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frames_q <= '0;
    else if (commit)
      frames_q <= frames_q + 16'h0001;
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: read data is registered before pready rises
  logic        ack_q;
  logic        bad_q;
  logic [31:0] rdata_q;
  logic        acc;
  logic        done;

  function automatic logic is_mapped(logic [`QDL_ADDR_W-1:0] a);
    return (a == `QDL_OFF_CTRL) || (a == `QDL_OFF_STAT)
        || (a >= `QDL_OFF_CH0 && a <= `QDL_OFF_CH3 && a[1:0] == 2'h0);
  endfunction : is_mapped

  function automatic logic [31:0] read_word(logic [`QDL_ADDR_W-1:0] a);
    logic [31:0] w;
    logic [1:0]  c;
    w = '0;
    c = a[3:2];
    if (a == `QDL_OFF_CTRL)
      w[`QDL_CTRL_RES_LSB +: 2] = res_q;
    else if (a == `QDL_OFF_STAT)
    begin
      w[2:0]                         = state_q;
      w[7:3]                         = count_q;
      w[`QDL_STAT_ARMED_BIT]         = ~sync_n_s;
      w[`QDL_STAT_CHAIN_BIT]         = chain_s;
      w[`QDL_STAT_FRAMES_LSB +: 16]  = frames_q;
    end
    else if (is_mapped(a))
    begin
      w[13:0]                    = in_q[c];
      w[`QDL_CH_DAC_LSB +: 14]   = dac_q[c];
      w[`QDL_CH_PEND_BIT]        = pend_q[c];
    end
    return w;
  endfunction : read_word

  assign acc  = psel & penable;
  assign done = acc & ack_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_q   <= 1'b0;
      bad_q   <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ack_q <= acc & ~ack_q;
      bad_q <= acc & ~ack_q & ~is_mapped(paddr);
      if (acc && !ack_q && !pwrite)
        rdata_q <= read_word(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      res_q <= qdl_res_t'(`QDL_CTRL_RST);
    else if (done && pwrite && paddr == `QDL_OFF_CTRL)
      res_q <= qdl_res_t'(pwdata[`QDL_CTRL_RES_LSB +: 2]);
  end

  assign pready  = ack_q;
  assign pslverr = ack_q & bad_q;
  assign prdata  = rdata_q;

endmodule : qdl_loader

// File: bench/qdl_props.sv
/*
  Port checker of the quad DAC loader.
  Assumes the bind at the foot onto every qdl_loader.
*/
`timescale 1ns/10ps
`include "qdl_params.svh"
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module qdl_props
  import qdl_pkg::*;
(
  // Clock, reset and APB
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [`QDL_ADDR_W-1:0] paddr,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Pins
  input wire logic                   sclk,
  input wire logic                   serial_out,
  input wire logic                   load_outputs_n,
  input wire logic                   async_clear_n,
  // Converter side
  input wire qdl_code_t [3:0]        dac_code,
  input wire logic [3:0]             dac_gain,
  input wire logic [3:0]             dac_buf_ref
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Five samples cover the pin synchroniser and the update flop
  sequence s_held;
    load_outputs_n [*5] ##0 (async_clear_n && $past(async_clear_n));
  endsequence
  sequence s_start;
    psel && $rose(penable);
  endsequence
  property p_clear;
    !async_clear_n |-> dac_code == '0 && dac_gain == '0 && dac_buf_ref == '0;
  endproperty
  property p_hold;
    s_held |-> $stable(dac_code) && $stable(dac_gain) && $stable(dac_buf_ref);
  endproperty
  property p_reset;
    $rose(presetn) |-> dac_code == '0 && dac_gain == '0 && !serial_out;
  endproperty
  property p_sdo;
    $changed(serial_out) |-> sclk || $past(sclk);
  endproperty
  property p_wait;
    s_start |-> !pready ##1 pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_in_access;
    pready |-> psel && penable;
  endproperty
  property p_err;
    pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h10, 8'h14,
                                         8'h18, 8'h1c});
  endproperty
  a_clear: assert property (p_clear) else $error("clear missed");
  a_hold: assert property (p_hold) else $error("dac moved");
  a_reset: assert property (p_reset) else $error("reset state");
  a_sdo: assert property (p_sdo) else $error("sdo off rise");
  a_wait: assert property (p_wait) else $error("apb wait state");
  a_pulse: assert property (p_pulse) else $error("pready long");
  a_in_access: assert property (p_in_access) else $error("pready idle");
  a_err: assert property (p_err) else $error("pslverr wrong");
endmodule : qdl_props

bind qdl_loader qdl_props u_props (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .sclk,
  .serial_out, .load_outputs_n, .async_clear_n, .dac_code, .dac_gain,
  .dac_buf_ref
);

// File: bench/qdl_host.sv
/*
  Serial host model: frames words onto the 3-wire link, MSB first.
  Assumes pclk at 100 MHz; sclk runs at 80 ns only while the frame task runs.
*/
`timescale 1ns/10ps
// ------------------------------------------------------------
// Host
// ------------------------------------------------------------
module qdl_host (
  // Clock
  input  wire logic pclk,
  // Serial link
  output logic      sclk,
  output logic      sync_n,
  output logic      din,
  input  wire logic serial_out
);
  logic [31:0] rx = '0;
  initial
  begin
    sclk = 1'b1;
    sync_n = 1'b1;
    din = 1'b0;
  end
  // Idle sclk stands high; s high runs clocks with the frame strobe off
  task automatic frame(input logic [31:0] w, input int n, input logic s);
    sync_n <= s;
    repeat (4) @(posedge pclk);
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk <= 1'b1;
      din <= w[i];
      repeat (4) @(posedge pclk);
      rx <= {rx[30:0], serial_out};
      sclk <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    sclk <= 1'b1;
    repeat (4) @(posedge pclk);
    sync_n <= 1'b1;
    din <= ~din;
    repeat (10) @(posedge pclk);
  endtask : frame
endmodule : qdl_host

// File: bench/quad_dac_serial_loader_tb.sv
/*
  Self-checking bench of the quad DAC loader.
  Assumes qdl_loader in rtl/ and the host model in bench/.
*/
`timescale 1ns/10ps
`include "qdl_params.svh"
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module quad_dac_serial_loader_tb
  import qdl_pkg::*;
;
  logic                   pclk, presetn, psel, penable, pwrite;
  logic [`QDL_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic                   pready, pslverr, er;
  logic                   sclk, sync_n, din, serial_out;
  logic                   chain_enable, load_outputs_n, async_clear_n;
  qdl_code_t [3:0]        dac_code;
  logic [3:0]             dac_gain, dac_buf_ref;
  int                     errors = 0;
  int                     samples_checked = 0;

  qdl_loader dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sclk, .sync_n, .din, .serial_out,
    .chain_enable, .load_outputs_n, .async_clear_n,
    .dac_code, .dac_gain, .dac_buf_ref
  );
  qdl_host host (.pclk, .sclk, .sync_n, .din, .serial_out);

  task automatic chk(input string nm, input logic [31:0] ex, got);
    samples_checked++;
    if (got !== ex)
    begin
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
      errors++;
    end
  endtask : chk
  task automatic dac(input int c, input logic [13:0] ex);
    chk("dac entry", {18'h0, ex},
        {18'h0, dac_gain[c], dac_buf_ref[c], dac_code[c]});
  endtask : dac
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; pready !== 1'b1 && n < 20; n++)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      errors++;
  endtask : apb
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // Each channel gets its own gain, buffer and code; load pin is low
  task automatic t_chan();
    logic [1:0] c2;
    for (int c = 0; c < 4; c++)
    begin
      dac(c, 14'h0);
      c2 = c[1:0];
      host.frame({16'h0, c2, c2[0], c2[1], 12'h5a0 + 12'(c)}, 16, 1'b0);
      dac(c, {c2[0], c2[1], 12'h5a0 + 12'(c)});
    end
    $display("t_chan done");
  endtask : t_chan
  task automatic t_res();
    logic [11:0] ex [3] = '{12'hfff, 12'hffc, 12'hff0};
    for (int r = 0; r < 3; r++)
    begin
      apb(1'b1, `QDL_OFF_CTRL, r);
      host.frame(32'h2fff, 16, 1'b0);
      dac(0, {2'b10, ex[r]});
    end
    apb(1'b0, `QDL_OFF_CTRL, 0);
    chk("ctrl", 32'h2, rd);
    apb(1'b0, 8'h08, 0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, `QDL_OFF_CTRL, 0);
    $display("t_res done");
  endtask : t_res
  task automatic t_abort();
    host.frame(32'h4123, 10, 1'b0);
    dac(1, {2'b10, 12'h5a1});
    host.frame(32'h4555, 16, 1'b1);
    dac(1, {2'b10, 12'h5a1});
    host.frame({12'h0, 16'h5321, 4'ha}, 20, 1'b0);
    dac(1, {2'b01, 12'h321});
    $display("t_abort done");
  endtask : t_abort
  task automatic t_hold();
    load_outputs_n <= 1'b1;
    repeat (4) @(posedge pclk);
    host.frame(32'h8777, 16, 1'b0);
    dac(2, {2'b01, 12'h5a2});
    apb(1'b0, 8'h18, 0);
    chk("ch2 input", 32'h8000_0777, {rd[31], 17'h0, rd[13:0]});
    load_outputs_n <= 1'b0;
    repeat (6) @(posedge pclk);
    dac(2, {2'b00, 12'h777});
    dac(3, {2'b11, 12'h5a3});
    apb(1'b0, 8'h18, 0);
    chk("ch2 readback", 32'h0777_0777, rd);
    $display("t_hold done");
  endtask : t_hold
  // Two words: the first ripples out, the last one stays here
  task automatic t_chain();
    chain_enable <= 1'b1;
    repeat (4) @(posedge pclk);
    host.frame({16'hcabc, 16'h1456}, 32, 1'b0);
    dac(0, {2'b01, 12'h456});
    dac(3, {2'b11, 12'h5a3});
    chk("chain out", 32'hcabc, {16'h0, host.rx[15:0]});
    apb(1'b0, `QDL_OFF_STAT, 0);
    chk("stat", 32'h000a_0281, rd);
    chain_enable <= 1'b0;
    $display("t_chain done");
  endtask : t_chain
  task automatic t_clear();
    async_clear_n <= 1'b0;
    repeat (2) @(posedge pclk);
    for (int c = 0; c < 4; c++)
      dac(c, 14'h0);
    async_clear_n <= 1'b1;
    $display("t_clear done");
  endtask : t_clear

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #100us;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, chain_enable, load_outputs_n} = '0;
    paddr = '0;
    pwdata = '0;
    async_clear_n = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_chan();
    t_res();
    t_abort();
    t_hold();
    t_chain();
    t_clear();
    tally_and_finish();
  end
endmodule : quad_dac_serial_loader_tb
